// >>> inc/demag_pkg.sv
// Package for the demagnetization event unit: register map, field positions,
// reset values, bus carriers and the step state encoding.
// Assumes a 32-bit AXI4-Lite slave with byte addresses on AXI_AW bits.
package demag_pkg;

	localparam int AXI_AW = 8;

	localparam logic [AXI_AW-1:0] CTRL_OFF   = 8'h00;
	localparam logic [AXI_AW-1:0] VALUE_OFF  = 8'h04;
	localparam logic [AXI_AW-1:0] STATUS_OFF = 8'h08;
	localparam logic [AXI_AW-1:0] MASK_OFF   = 8'h0c;

	localparam int CTRL_HW_BIT   = 0;
	localparam int CTRL_SIM_BIT  = 1;
	localparam int CTRL_FALL_BIT = 2;
	localparam int CTRL_FILT_LSB = 4;
	localparam int FLAG_BIT      = 0;
	localparam int MASK_BIT      = 0;

	localparam logic       HW_EN_RST  = 1'b0;
	localparam logic       SIM_EN_RST = 1'b0;
	localparam logic       FALL_RST   = 1'b0;
	localparam logic       FLAG_RST   = 1'b0;
	localparam logic       MASK_RST   = 1'b0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		STEP_IDLE  = 2'h1,
		STEP_ARMED = 2'h2
	} step_e;

	typedef struct packed {
		logic [AXI_AW-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [AXI_AW-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axil_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_s;

endpackage

// >>> rtl/demag_edge_filter.sv
// Consecutive edge counter on the selected rotor position input.
// Assumes the input is already synchronous to aclk.
`timescale 1ns/10ps
module demag_edge_filter #(
	parameter int FW = 3
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          sense,
	input  wire logic          falling,
	input  wire logic          clear,
	input  wire logic [FW-1:0] need,
	output logic               hit
);

	typedef struct packed {
		logic          prev;
		logic [FW-1:0] cnt;
	} filt_state_s;

	filt_state_s st_r;
	filt_state_s st_nxt;
	logic        edge_seen;

	always_comb
	begin
		st_nxt = st_r;
		edge_seen = falling ? (st_r.prev & ~sense) : (~st_r.prev & sense);
		hit = 1'b0;
		st_nxt.prev = sense;
		if (clear)
		begin
			st_nxt.cnt = '0;
		end
		else if (edge_seen)
		begin
			// Field value n asks for n+1 edges
			if (st_r.cnt == need)
			begin
				hit = 1'b1; // [RULE_01]
				st_nxt.cnt = '0;
			end
			else
			begin
				st_nxt.cnt = st_r.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	property p_filter_count;
		@(posedge aclk) disable iff (!aresetn)
		hit |-> (st_r.cnt == need) && !clear && (st_r.prev != sense);
	endproperty
	a_filter_count: assert property (p_filter_count) // [RULE_01]
		else $error("filter hit before programmed edge count");

endmodule // demag_edge_filter

// >>> rtl/demag_event_unit.sv
// Demagnetization event unit: hardware and simulated events, capture of the
// step timer, status flag with mask, and an AXI4-Lite register slave.
// Assumes commutation_event is a one-cycle pulse and the timer is synchronous.
// Behaviour
// RULE_01: Hardware event after programmed consecutive edge count
// RULE_02: Hardware event captures timer into value register
// RULE_03: Simulated event when timer matches value register
// RULE_04: First of both sources gives single step event
// RULE_05: Software keeps simulated event after hardware event
// RULE_06: Hardware disabled: simulated event alone masks step
// RULE_07: Software sets mask longer than real demagnetization
// RULE_08: Event sets flag; masked flag requests interrupt
// RULE_09: At commutation, late value fires now, takes count
// RULE_10: Software avoids value writes during capture/compare
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module demag_event_unit #(
	parameter int TW = 8,
	parameter int FW = 3
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire demag_pkg::axil_req_s axi_req,
	output demag_pkg::axil_rsp_s     axi_rsp,
	input  wire logic                position_sense_input,
	input  wire logic                commutation_event,
	input  wire logic [TW-1:0]       motor_step_timer,
	output logic                     demag_event,
	output logic                     demag_irq
);

	typedef struct packed {
		demag_pkg::step_e           step;
		logic                       hw_demag_enable;
		logic                       sim_demag_enable;
		logic                       falling;
		logic [FW-1:0]              demag_event_filter;
		logic [TW-1:0]              demag_value_reg;
		logic                       demag_flag;
		logic                       demag_irq_mask;
		logic                       event_out;
		logic                       aw_got;
		logic [demag_pkg::AXI_AW-1:0] awaddr;
		logic                       w_got;
		logic [31:0]                wdata;
		logic [3:0]                 wstrb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       rvalid;
		logic [31:0]                rdata;
		logic [1:0]                 rresp;
	} demag_state_s;

	demag_state_s st_r;
	demag_state_s st_nxt;
	logic         hw_hit;
	logic         filt_clear;
	logic         armed;
	logic         sim_hit;
	logic         fire;
	logic         capture;

	assign armed = (st_r.step == demag_pkg::STEP_ARMED);
	// Filter only counts within an armed step, so stale edges never carry over
	assign filt_clear = !armed || !st_r.hw_demag_enable || commutation_event; // [RULE_06]
	assign sim_hit = armed && st_r.sim_demag_enable
		&& (motor_step_timer == st_r.demag_value_reg); // [RULE_03]

	demag_edge_filter #(
		.FW (FW)
	) u_filter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.sense   (position_sense_input),
		.falling (st_r.falling),
		.clear   (filt_clear),
		.need    (st_r.demag_event_filter),
		.hit     (hw_hit)
	);

	assign axi_rsp.awready = !st_r.aw_got && !st_r.bvalid;
	assign axi_rsp.wready  = !st_r.w_got && !st_r.bvalid;
	assign axi_rsp.bvalid  = st_r.bvalid;
	assign axi_rsp.bresp   = st_r.bresp;
	assign axi_rsp.arready = !st_r.rvalid;
	assign axi_rsp.rvalid  = st_r.rvalid;
	assign axi_rsp.rdata   = st_r.rdata;
	assign axi_rsp.rresp   = st_r.rresp;
	assign demag_event     = st_r.event_out;
	assign demag_irq       = st_r.demag_flag && st_r.demag_irq_mask; // [RULE_08]

	always_comb
	begin
		st_nxt = st_r;
		fire = 1'b0;
		capture = 1'b0;

		// Register bus, write side: address and data in either order
		if (axi_req.awvalid && axi_rsp.awready)
		begin
			st_nxt.aw_got = 1'b1;
			st_nxt.awaddr = axi_req.awaddr;
		end
		if (axi_req.wvalid && axi_rsp.wready)
		begin
			st_nxt.w_got = 1'b1;
			st_nxt.wdata = axi_req.wdata;
			st_nxt.wstrb = axi_req.wstrb;
		end
		if (st_r.aw_got && st_r.w_got)
		begin
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = demag_pkg::RESP_OKAY;
			if (st_r.awaddr[demag_pkg::AXI_AW-1:2] == demag_pkg::CTRL_OFF[demag_pkg::AXI_AW-1:2])
			begin
				if (st_r.wstrb[0])
				begin
					st_nxt.hw_demag_enable = st_r.wdata[demag_pkg::CTRL_HW_BIT];
					st_nxt.sim_demag_enable = st_r.wdata[demag_pkg::CTRL_SIM_BIT];
					st_nxt.falling = st_r.wdata[demag_pkg::CTRL_FALL_BIT];
					st_nxt.demag_event_filter = st_r.wdata[demag_pkg::CTRL_FILT_LSB +: FW];
				end
			end
			else if (st_r.awaddr[demag_pkg::AXI_AW-1:2] == demag_pkg::VALUE_OFF[demag_pkg::AXI_AW-1:2])
			begin
				for (int i = 0; i < TW; i++)
				begin
					if (st_r.wstrb[i/8])
					begin
						st_nxt.demag_value_reg[i] = st_r.wdata[i];
					end
				end
			end
			else if (st_r.awaddr[demag_pkg::AXI_AW-1:2] == demag_pkg::STATUS_OFF[demag_pkg::AXI_AW-1:2])
			begin
				// Write one to clear; an event in this cycle wins below
				if (st_r.wstrb[0] && st_r.wdata[demag_pkg::FLAG_BIT])
				begin
					st_nxt.demag_flag = 1'b0;
				end
			end
			else if (st_r.awaddr[demag_pkg::AXI_AW-1:2] == demag_pkg::MASK_OFF[demag_pkg::AXI_AW-1:2])
			begin
				if (st_r.wstrb[0])
				begin
					st_nxt.demag_irq_mask = st_r.wdata[demag_pkg::MASK_BIT];
				end
			end
			else
			begin
				st_nxt.bresp = demag_pkg::RESP_SLVERR;
			end
		end
		if (st_r.bvalid && axi_req.bready)
		begin
			st_nxt.bvalid = 1'b0;
		end

		// Register bus, read side
		if (axi_req.arvalid && axi_rsp.arready)
		begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = '0;
			st_nxt.rresp = demag_pkg::RESP_OKAY;
			if (axi_req.araddr[demag_pkg::AXI_AW-1:2] == demag_pkg::CTRL_OFF[demag_pkg::AXI_AW-1:2])
			begin
				st_nxt.rdata[demag_pkg::CTRL_HW_BIT] = st_r.hw_demag_enable;
				st_nxt.rdata[demag_pkg::CTRL_SIM_BIT] = st_r.sim_demag_enable;
				st_nxt.rdata[demag_pkg::CTRL_FALL_BIT] = st_r.falling;
				st_nxt.rdata[demag_pkg::CTRL_FILT_LSB +: FW] = st_r.demag_event_filter;
			end
			else if (axi_req.araddr[demag_pkg::AXI_AW-1:2] == demag_pkg::VALUE_OFF[demag_pkg::AXI_AW-1:2])
			begin
				st_nxt.rdata[TW-1:0] = st_r.demag_value_reg;
			end
			else if (axi_req.araddr[demag_pkg::AXI_AW-1:2] == demag_pkg::STATUS_OFF[demag_pkg::AXI_AW-1:2])
			begin
				st_nxt.rdata[demag_pkg::FLAG_BIT] = st_r.demag_flag;
			end
			else if (axi_req.araddr[demag_pkg::AXI_AW-1:2] == demag_pkg::MASK_OFF[demag_pkg::AXI_AW-1:2])
			begin
				st_nxt.rdata[demag_pkg::MASK_BIT] = st_r.demag_irq_mask;
			end
			else
			begin
				st_nxt.rresp = demag_pkg::RESP_SLVERR;
			end
		end
		else if (st_r.rvalid && axi_req.rready)
		begin
			st_nxt.rvalid = 1'b0;
		end

		// Step sequencing: one event per commutation step
		case (st_r.step)
			demag_pkg::STEP_IDLE:
			begin
				if (commutation_event)
				begin
					st_nxt.step = demag_pkg::STEP_ARMED;
				end
			end
			demag_pkg::STEP_ARMED:
			begin
				if (commutation_event)
				begin
					st_nxt.step = demag_pkg::STEP_ARMED;
				end
				else if (st_r.hw_demag_enable && hw_hit) // [RULE_01] [RULE_06]
				begin
					fire = 1'b1;
					capture = 1'b1; // [RULE_02]
					st_nxt.step = demag_pkg::STEP_IDLE;
				end
				else if (sim_hit) // [RULE_03] [RULE_04]
				begin
					fire = 1'b1;
					st_nxt.step = demag_pkg::STEP_IDLE;
				end
			end
			default:
			begin
				st_nxt.step = demag_pkg::STEP_IDLE;
			end
		endcase

		// A value already passed at commutation fires at once
		if (commutation_event && st_r.sim_demag_enable
			&& (st_r.demag_value_reg <= motor_step_timer)) // [RULE_09]
		begin
			fire = 1'b1;
			capture = 1'b1;
			st_nxt.step = demag_pkg::STEP_IDLE;
		end

		// Hardware update of the value wins over a bus write in the same cycle
		if (capture)
		begin
			st_nxt.demag_value_reg = motor_step_timer; // [RULE_02] [RULE_09]
		end
		st_nxt.event_out = fire; // [RULE_04]
		if (fire)
		begin
			st_nxt.demag_flag = 1'b1; // [RULE_08]
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st_r <= '0;
			st_r.step <= demag_pkg::STEP_IDLE;
			st_r.hw_demag_enable <= demag_pkg::HW_EN_RST;
			st_r.sim_demag_enable <= demag_pkg::SIM_EN_RST;
			st_r.falling <= demag_pkg::FALL_RST;
			st_r.demag_flag <= demag_pkg::FLAG_RST;
			st_r.demag_irq_mask <= demag_pkg::MASK_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_capture;
		armed && !commutation_event && st_r.hw_demag_enable && hw_hit
		|=> st_r.event_out && (st_r.demag_value_reg == $past(motor_step_timer));
	endproperty
	a_capture: assert property (p_capture) // [RULE_02]
		else $error("hardware event did not capture timer");

	property p_sim_match;
		armed && !commutation_event && !hw_hit && sim_hit |=> st_r.event_out && !armed;
	endproperty
	a_sim_match: assert property (p_sim_match) // [RULE_03]
		else $error("simulated match gave no event");

	property p_single;
		(st_r.step == demag_pkg::STEP_IDLE) && !commutation_event |=> !st_r.event_out;
	endproperty
	a_single: assert property (p_single) // [RULE_04]
		else $error("second event within one step");

	property p_hw_off;
		armed && !commutation_event && !st_r.hw_demag_enable && !sim_hit |=> !st_r.event_out;
	endproperty
	a_hw_off: assert property (p_hw_off) // [RULE_06]
		else $error("event with hardware source disabled");

	property p_flag;
		st_r.event_out |-> st_r.demag_flag && (demag_irq == st_r.demag_irq_mask);
	endproperty
	a_flag: assert property (p_flag) // [RULE_08]
		else $error("event without flag or interrupt");

	property p_immediate;
		commutation_event && st_r.sim_demag_enable && (st_r.demag_value_reg <= motor_step_timer)
		|=> st_r.event_out && (st_r.demag_value_reg == $past(motor_step_timer)) && !armed;
	endproperty
	a_immediate: assert property (p_immediate) // [RULE_09]
		else $error("late value did not fire at commutation");

endmodule // demag_event_unit

// >>> verif/winding_model.sv
// Winding voltage seen through the rotor position comparator.
// Assumes kick is a one-cycle request from the bench; each gives one
// rising and one falling edge, the comparator line is always driven.
`timescale 1ns/10ps
module winding_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic kick,
	output logic      sense
);
	logic [1:0] hold_r;

	// Level held a few cycles, as a real edge settles before it falls back
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sense  <= 1'b0;
			hold_r <= 2'h0;
		end
		else if (kick)
		begin
			sense  <= 1'b1;
			hold_r <= 2'h2;
		end
		else if (hold_r != 2'h0)
		begin
			hold_r <= hold_r - 2'h1;
			sense  <= (hold_r != 2'h1);
		end
	end
endmodule // winding_model

// >>> verif/tb.sv
// Bench for the demag event unit: bus tasks, step stimulus, event checks.
// Assumes the winding model drives the position input and the bench the timer.
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] A_CTRL = demag_pkg::CTRL_OFF;
	localparam logic [7:0] A_VAL  = demag_pkg::VALUE_OFF;
	localparam logic [7:0] A_STAT = demag_pkg::STATUS_OFF;
	localparam logic [7:0] A_MASK = demag_pkg::MASK_OFF;
	localparam logic [1:0] OK     = demag_pkg::RESP_OKAY;
	localparam logic [1:0] ERR    = demag_pkg::RESP_SLVERR;

	logic                 aclk;
	logic                 aresetn;
	demag_pkg::axil_req_s req;
	demag_pkg::axil_rsp_s rsp;
	logic                 comm;
	logic                 tz;
	logic                 kick;
	logic                 sense;
	logic [7:0]           tmr;
	logic                 ev;
	logic                 irq;
	logic [7:0]           ev_tmr;
	int                   ev_n;
	int                   n0;
	int                   cyc;
	int                   fail_count;
	int                   num_checks;

	demag_event_unit #(.TW(8), .FW(3)) i_dut (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.position_sense_input(sense), .commutation_event(comm),
		.motor_step_timer(tmr), .demag_event(ev), .demag_irq(irq));
	winding_model i_wind (.aclk(aclk), .aresetn(aresetn), .kick(kick), .sense(sense));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Event seen one edge late, so the deciding timer value is one less
	always @(posedge aclk)
	begin
		tmr <= tz ? 8'h00 : tmr + 8'h01;
		cyc <= cyc + 1;
		if (ev === 1'b1)
		begin
			ev_n   <= ev_n + 1;
			ev_tmr <= tmr - 8'h01;
		end
		if (cyc == 3000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		req.awaddr  <= a;
		req.wdata   <= v;
		req.awvalid <= 1'b1;
		req.wvalid  <= 1'b1;
		req.bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (req.awvalid && rsp.awready)
				req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready)
				req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		req.bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
	endtask

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		req.araddr  <= a;
		req.arvalid <= 1'b1;
		req.rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (req.arvalid && rsp.arready)
				req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		req.rready <= 1'b0;
		chk(n, e, rsp.rdata);
		chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
	endtask

	// Timer zeroed one edge ahead, so the late-value check sees a fresh step
	task automatic commute(input logic z);
		@(posedge aclk);
		tz   <= z;
		@(posedge aclk);
		tz   <= 1'b0;
		comm <= 1'b1;
		@(posedge aclk);
		comm <= 1'b0;
	endtask

	task automatic hit;
		@(posedge aclk);
		kick <= 1'b1;
		@(posedge aclk);
		kick <= 1'b0;
		repeat (4) @(posedge aclk);
	endtask

	// Counts events since n0 over a window, then restarts the window
	task automatic evs(input int lim, input int exp);
		repeat (lim) @(posedge aclk);
		#1;
		chk("events", exp, ev_n - n0);
		n0 = ev_n;
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		req = '0;
		req.wstrb = 4'hf;
		aresetn = 1'b0;
		comm = 1'b0;
		tz = 1'b0;
		kick = 1'b0;
		tmr = 8'h00;
		ev_tmr = 8'h00;
		ev_n = 0;
		n0 = 0;
		cyc = 0;
		fail_count = 0;
		num_checks = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd("ctrl", A_CTRL, 32'h0, OK);
		rd("value", A_VAL, 32'h0, OK);
		rd("status", A_STAT, 32'h0, OK);
		rd("mask", A_MASK, 32'h0, OK);
		rd("unmapped", 8'h10, 32'h0, ERR);
		wr(8'h10, 32'h1, ERR);
		wr(A_MASK, 32'h1, OK);
		wr(A_CTRL, 32'h1, OK);
		commute(1'b1);
		n0 = ev_n;
		hit();
		evs(2, 1);
		rd("capture", A_VAL, {24'h0, ev_tmr}, OK);
		chk("irq", 32'h1, {31'h0, irq});
		rd("flag", A_STAT, 32'h1, OK);
		hit();
		evs(2, 0);
		wr(A_STAT, 32'h1, OK);
		chk("irq cleared", 32'h0, {31'h0, irq});
		// Filter of three rising edges
		wr(A_CTRL, 32'h21, OK);
		commute(1'b1);
		n0 = ev_n;
		hit();
		hit();
		evs(2, 0);
		hit();
		evs(2, 1);
		// Falling edge only: rising edge ignored, falling one five counts in
		wr(A_CTRL, 32'h5, OK);
		commute(1'b1);
		n0 = ev_n;
		hit();
		evs(2, 1);
		chk("falling time", 32'h5, {24'h0, ev_tmr});
		wr(A_MASK, 32'h0, OK);
		wr(A_STAT, 32'h1, OK);
		wr(A_VAL, 32'h14, OK);
		wr(A_CTRL, 32'h2, OK);
		commute(1'b1);
		n0 = ev_n;
		hit();
		evs(24, 1);
		chk("sim time", 32'h14, {24'h0, ev_tmr});
		chk("irq masked", 32'h0, {31'h0, irq});
		rd("sim flag", A_STAT, 32'h1, OK);
		rd("value kept", A_VAL, 32'h14, OK);
		wr(A_STAT, 32'h1, OK);
		wr(A_VAL, 32'h3c, OK);
		wr(A_CTRL, 32'h3, OK);
		commute(1'b1);
		n0 = ev_n;
		hit();
		evs(80, 1);
		rd("both capture", A_VAL, {24'h0, ev_tmr}, OK);
		// Value already behind the timer when the step starts
		wr(A_CTRL, 32'h0, OK);
		commute(1'b1);
		repeat (30) @(posedge aclk);
		wr(A_VAL, 32'h5, OK);
		wr(A_CTRL, 32'h2, OK);
		n0 = ev_n;
		commute(1'b0);
		evs(1, 1);
		rd("late value", A_VAL, {24'h0, ev_tmr}, OK);
		chk("late", 32'h1, {31'h0, ev_tmr > 8'h05});
		wrap_up();
	end
endmodule // tb
